// ==== verilog/sfc_pkg.sv ====
package sfc_pkg;
  localparam int unsigned NUM_CH = 10;
  localparam int unsigned NUM_DED = 5;
  localparam int unsigned NUM_DUAL = 5;
  localparam int unsigned CODE_W = 8;
  localparam int unsigned HYST_W = 5;
  localparam int unsigned RANGE_W = 2;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned PW_W = 14;
  localparam int unsigned CODE_FULL = 255;
  localparam logic [HYST_W-1:0] HYST_MAX = 5'h1f;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned OSC_HZ = 100_000;
  localparam int unsigned OSC_HALF = CLK_HZ / OSC_HZ / 2;
  localparam int unsigned FILT_MAX_US = 100;
  localparam int unsigned PULSE_MAX_US = 100;
  localparam int unsigned FILT_MAX_CYC = FILT_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PULSE_MAX_CYC = PULSE_MAX_US * (CLK_HZ / 1_000_000);
  // Range codes; span/bottom in millivolts (bottom 0.573 V held as 573).
  localparam logic [RANGE_W-1:0] RNG_LOW = 2'h0;
  localparam logic [RANGE_W-1:0] RNG_MID = 2'h1;
  localparam logic [RANGE_W-1:0] RNG_HIGH = 2'h2;
  localparam logic [RANGE_W-1:0] RNG_TOP = 2'h3;
  localparam int unsigned BOT_MV_0 = 573;
  localparam int unsigned SPAN_MV_0 = 802;
  localparam int unsigned BOT_MV_1 = 1250;
  localparam int unsigned SPAN_MV_1 = 1750;
  localparam int unsigned BOT_MV_2 = 2500;
  localparam int unsigned SPAN_MV_2 = 3500;
  localparam int unsigned BOT_MV_3 = 4800;
  localparam int unsigned SPAN_MV_3 = 9600;
  localparam int unsigned HV_CH = 4;
  localparam int unsigned MV_W = 16;
  typedef enum logic [1:0] {
    SFC_MODE_UV = 2'b00,
    SFC_MODE_OV = 2'b01,
    SFC_MODE_WIN = 2'b11
  } sfc_mode_t;
  localparam logic [1:0] MODE_UV = 2'b00;
  localparam logic [1:0] MODE_OV = 2'b01;
  localparam logic [1:0] MODE_WIN = 2'b11;
  typedef enum logic [1:0] {
    SFC_EDGE_IDLE = 2'b00,
    SFC_EDGE_PULSE = 2'b01
  } sfc_edge_t;
  localparam int unsigned APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_FILT = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_PULSE = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_CH_BASE = 8'h40;
  localparam logic [APB_AW-1:0] ADDR_CH_LAST = 8'h64;
  localparam int unsigned CH_SHIFT = 2;
  localparam int unsigned FIELD_UV_LSB = 0;
  localparam int unsigned FIELD_OV_LSB = 8;
  localparam int unsigned FIELD_HYS_LSB = 16;
  localparam int unsigned FIELD_RNG_LSB = 21;
  localparam int unsigned FIELD_MODE_LSB = 24;
  localparam int unsigned FIELD_EN_BIT = 26;
  localparam int unsigned ST_WARN_LSB = 16;
  localparam int unsigned ST_WARN_ALL = 24;
  localparam int unsigned CTRL_LOGIC_LSB = 0;
  localparam int unsigned CTRL_EDGE_LSB = 8;
  localparam int unsigned CTRL_PD_LSB = 16;
  localparam logic [CODE_W-1:0] UV_RESET = 8'h00;
  localparam logic [CODE_W-1:0] OV_RESET = 8'hff;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  // Threshold in mV for code n of range r.
  function automatic logic [MV_W-1:0] code_to_mv(
    input logic [RANGE_W-1:0] r, input logic [CODE_W-1:0] n);
    int unsigned span;
    int unsigned bot;
    span = SPAN_MV_0;
    bot = BOT_MV_0;
    unique case (r)
      RNG_LOW: begin span = SPAN_MV_0; bot = BOT_MV_0; end
      RNG_MID: begin span = SPAN_MV_1; bot = BOT_MV_1; end
      RNG_HIGH: begin span = SPAN_MV_2; bot = BOT_MV_2; end
      RNG_TOP: begin span = SPAN_MV_3; bot = BOT_MV_3; end
    endcase
    return MV_W'((span * 32'(n)) / CODE_FULL + bot);
  endfunction : code_to_mv

  // Hysteresis in mV for 5-bit code h.
  function automatic logic [MV_W-1:0] hyst_to_mv(
    input logic [RANGE_W-1:0] r, input logic [HYST_W-1:0] h);
    int unsigned span;
    span = SPAN_MV_0;
    unique case (r)
      RNG_LOW: span = SPAN_MV_0;
      RNG_MID: span = SPAN_MV_1;
      RNG_HIGH: span = SPAN_MV_2;
      RNG_TOP: span = SPAN_MV_3;
    endcase
    return MV_W'((span * 32'(h)) / CODE_FULL);
  endfunction : hyst_to_mv
endpackage : sfc_pkg

// ==== verilog/sfc_top.sv ====
// Operation
// - Detector modes: undervoltage, overvoltage or window.
// - Each threshold is an 8-bit code.
// - Threshold equals span times code/255 plus bottom.
// - Four ranges with fixed bottom and span.
// - Range choice limited per input type.
// - Hysteresis applies only after fault asserts.
// - Hysteresis is 5-bit code, span*code/255.
// - Glitch filter ends every detector.
// - Filter timeout up to 100 us, suppresses short.
// - Accepted transitions lag by the timeout.
// - Five dedicated, five dual; analog excludes logic.
// - Warning detector uses primary input range.
// - Warnings readable and ORed to one signal.
// - Logic input level mode buffers input.
// - Edge mode emits programmable-width pulse.
// - Logic inputs share the glitch filter.
// - Selectable weak pull-down per logic input.
// - Logic outputs feed the sequencing engine.
// - On-chip 100 kHz clock generated.
// - Engine sees filtered status of ten inputs.
`timescale 1ns/1ps
module sfc_top (
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Channels 0..3 positive inputs, 4 high-voltage, 5..9 dual-function.
  input wire logic [sfc_pkg::NUM_CH-1:0][sfc_pkg::MV_W-1:0] input_mv_in,
  input wire logic [sfc_pkg::NUM_DUAL-1:0] dual_function_input_in,
  input wire logic [sfc_pkg::APB_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [sfc_pkg::NUM_CH-1:0] supply_fault_detector_out,
  output logic [sfc_pkg::NUM_DED-1:0] warning_out,
  output logic warning_any_out,
  output logic [sfc_pkg::NUM_DUAL-1:0] logic_input_out,
  output logic [sfc_pkg::NUM_DUAL-1:0] pull_down_en_out,
  output logic osc_clk_out
);
  import sfc_pkg::*;

  logic [NUM_CH-1:0][CODE_W-1:0] uv_code;
  logic [NUM_CH-1:0][CODE_W-1:0] ov_code;
  logic [NUM_CH-1:0][HYST_W-1:0] hyst_code;
  logic [NUM_CH-1:0][RANGE_W-1:0] range_sel;
  logic [NUM_CH-1:0][1:0] mode_sel;
  logic [NUM_CH-1:0] det_en;
  logic [NUM_DUAL-1:0] logic_mode;
  logic [NUM_DUAL-1:0] edge_mode;
  logic [NUM_DUAL-1:0] pd_sel;
  logic [CNT_W-1:0] filt_cycles;
  logic [PW_W-1:0] pulse_cycles;
  logic [NUM_CH-1:0][MV_W-1:0] mv_q;
  logic [NUM_DUAL-1:0] dig_q;
  logic [NUM_CH-1:0] uv_flag;
  logic [NUM_CH-1:0] ov_flag;
  logic [NUM_CH-1:0] raw_fault;
  logic [NUM_CH-1:0] filt_out;
  logic [NUM_CH-1:0][CNT_W-1:0] filt_cnt;
  logic [NUM_DUAL-1:0] dfilt_out;
  logic [NUM_DUAL-1:0][CNT_W-1:0] dfilt_cnt;
  logic [NUM_DUAL-1:0] dfilt_prev;
  sfc_edge_t [NUM_DUAL-1:0] edge_st;
  logic [NUM_DUAL-1:0][PW_W-1:0] pulse_cnt;
  logic [15:0] osc_cnt;
  logic wr_en;
  logic rd_en;
  logic ch_hit;
  logic [3:0] ch_idx;
  logic [31:0] next_rdata;

  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && penable_in && !pwrite_in;
  assign ch_hit = (paddr_in >= ADDR_CH_BASE) && (paddr_in <= ADDR_CH_LAST);
  assign ch_idx = 4'((paddr_in - ADDR_CH_BASE) >> CH_SHIFT);

  // Range legal for a channel; illegal picks fall back to the nearest legal.
  function automatic logic [RANGE_W-1:0] legal_range(
    input int unsigned ch, input logic [RANGE_W-1:0] r);
    logic [RANGE_W-1:0] res;
    res = r;
    if (ch == HV_CH) begin
      if (r < RNG_HIGH) res = RNG_HIGH;
    end else if (ch < NUM_DED) begin
      if (r == RNG_TOP) res = RNG_HIGH;
    end else begin
      res = RNG_LOW;
    end
    return res;
  endfunction : legal_range

  // Glitch filter step: output follows input once it has held filt cycles.
  function automatic logic [CNT_W:0] filt_step(
    input logic in_v, input logic out_v, input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim);
    logic [CNT_W:0] res;
    res = {out_v, {CNT_W{1'b0}}};
    if (in_v != out_v) begin
      if (cnt + 1'b1 >= lim) res = {in_v, {CNT_W{1'b0}}};
      else res = {out_v, CNT_W'(cnt + 1'b1)};
    end
    return res;
  endfunction : filt_step

  // Register file writes.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        uv_code[i] <= UV_RESET;
        ov_code[i] <= OV_RESET;
        hyst_code[i] <= '0;
        range_sel[i] <= legal_range(i, RNG_LOW);
        mode_sel[i] <= MODE_UV;
        det_en[i] <= 1'b0;
      end
      logic_mode <= '0;
      edge_mode <= '0;
      pd_sel <= '0;
      filt_cycles <= '0;
      pulse_cycles <= '0;
    end else if (wr_en) begin
      if (ch_hit && pstrb_in == 4'hf) begin
        uv_code[ch_idx] <= pwdata_in[FIELD_UV_LSB +: CODE_W];
        ov_code[ch_idx] <= pwdata_in[FIELD_OV_LSB +: CODE_W];
        hyst_code[ch_idx] <= pwdata_in[FIELD_HYS_LSB +: HYST_W];
        range_sel[ch_idx] <= legal_range(32'(ch_idx),
          pwdata_in[FIELD_RNG_LSB +: RANGE_W]);
        mode_sel[ch_idx] <= (pwdata_in[FIELD_MODE_LSB +: 2] == 2'b10) ?
          MODE_WIN : pwdata_in[FIELD_MODE_LSB +: 2];
        det_en[ch_idx] <= pwdata_in[FIELD_EN_BIT];
      end else if (paddr_in == ADDR_CTRL) begin
        logic_mode <= pwdata_in[CTRL_LOGIC_LSB +: NUM_DUAL];
        edge_mode <= pwdata_in[CTRL_EDGE_LSB +: NUM_DUAL];
        pd_sel <= pwdata_in[CTRL_PD_LSB +: NUM_DUAL];
      end else if (paddr_in == ADDR_FILT) begin
        filt_cycles <= (pwdata_in[CNT_W-1:0] > CNT_W'(FILT_MAX_CYC)) ?
          CNT_W'(FILT_MAX_CYC) : pwdata_in[CNT_W-1:0];
      end else if (paddr_in == ADDR_PULSE) begin
        pulse_cycles <= (pwdata_in[PW_W-1:0] > PW_W'(PULSE_MAX_CYC)) ?
          PW_W'(PULSE_MAX_CYC) : pwdata_in[PW_W-1:0];
      end
    end
  end

  // Read mux; unmapped reads return zero with an error.
  always_comb begin
    next_rdata = ZERO32;
    if (ch_hit) begin
      next_rdata[FIELD_UV_LSB +: CODE_W] = uv_code[ch_idx];
      next_rdata[FIELD_OV_LSB +: CODE_W] = ov_code[ch_idx];
      next_rdata[FIELD_HYS_LSB +: HYST_W] = hyst_code[ch_idx];
      next_rdata[FIELD_RNG_LSB +: RANGE_W] = range_sel[ch_idx];
      next_rdata[FIELD_MODE_LSB +: 2] = mode_sel[ch_idx];
      next_rdata[FIELD_EN_BIT] = det_en[ch_idx];
    end else if (paddr_in == ADDR_CTRL) begin
      next_rdata[CTRL_LOGIC_LSB +: NUM_DUAL] = logic_mode;
      next_rdata[CTRL_EDGE_LSB +: NUM_DUAL] = edge_mode;
      next_rdata[CTRL_PD_LSB +: NUM_DUAL] = pd_sel;
    end else if (paddr_in == ADDR_STATUS) begin
      next_rdata[NUM_CH-1:0] = supply_fault_detector_out;
      next_rdata[ST_WARN_LSB +: NUM_DED] = warning_out;
      next_rdata[ST_WARN_ALL] = warning_any_out;
    end else if (paddr_in == ADDR_FILT) begin
      next_rdata[CNT_W-1:0] = filt_cycles;
    end else if (paddr_in == ADDR_PULSE) begin
      next_rdata[PW_W-1:0] = pulse_cycles;
    end
  end

  // APB answer: no wait state, so pready is high in the first access cycle.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= ZERO32;
    end else if (psel_in && !penable_in) begin
      pready_out <= 1'b1;
      pslverr_out <= !(ch_hit || paddr_in == ADDR_CTRL ||
        paddr_in == ADDR_STATUS || paddr_in == ADDR_FILT ||
        paddr_in == ADDR_PULSE);
      prdata_out <= pwrite_in ? ZERO32 : next_rdata;
    end else begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Inputs are registered once before comparison and filtering.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mv_q <= '0;
      dig_q <= '0;
    end else begin
      mv_q <= input_mv_in;
      dig_q <= dual_function_input_in;
    end
  end

  // Comparators with hysteresis; a dual channel in logic mode is a warning
  // detector on its mapped dedicated rail and uses that rail's range.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      uv_flag <= '0;
      ov_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        logic [MV_W-1:0] v;
        logic [RANGE_W-1:0] r;
        logic [MV_W-1:0] uv_t;
        logic [MV_W-1:0] ov_t;
        logic [MV_W-1:0] hy;
        v = mv_q[i];
        r = range_sel[i];
        if (i >= NUM_DED && logic_mode[i-NUM_DED]) begin
          v = mv_q[i-NUM_DED];
          r = range_sel[i-NUM_DED];
        end
        uv_t = code_to_mv(r, uv_code[i]);
        ov_t = code_to_mv(r, ov_code[i]);
        hy = hyst_to_mv(r, (hyst_code[i] > HYST_MAX) ?
          HYST_MAX : hyst_code[i]);
        if (!uv_flag[i]) uv_flag[i] <= v < uv_t;
        else uv_flag[i] <= v < MV_W'(uv_t + hy);
        if (!ov_flag[i]) ov_flag[i] <= v > ov_t;
        else ov_flag[i] <= MV_W'(v + hy) > ov_t;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      unique case (mode_sel[i])
        MODE_UV: raw_fault[i] = det_en[i] && uv_flag[i];
        MODE_OV: raw_fault[i] = det_en[i] && ov_flag[i];
        default: raw_fault[i] = det_en[i] && (uv_flag[i] || ov_flag[i]);
      endcase
    end
  end

  // Glitch filters on every comparator output.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      filt_out <= '0;
      filt_cnt <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        {filt_out[i], filt_cnt[i]} <= filt_step(raw_fault[i], filt_out[i],
          filt_cnt[i], filt_cycles);
      end
    end
  end

  // Same filter on logic inputs, then level or edge conditioning.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dfilt_out <= '0;
      dfilt_cnt <= '0;
      dfilt_prev <= '0;
      edge_st <= '{default: SFC_EDGE_IDLE};
      pulse_cnt <= '0;
    end else begin
      for (int i = 0; i < NUM_DUAL; i++) begin
        {dfilt_out[i], dfilt_cnt[i]} <= filt_step(dig_q[i], dfilt_out[i],
          dfilt_cnt[i], filt_cycles);
        dfilt_prev[i] <= dfilt_out[i];
        unique case (edge_st[i])
          SFC_EDGE_IDLE: begin
            if (edge_mode[i] && dfilt_out[i] != dfilt_prev[i] &&
                pulse_cycles != '0) begin
              edge_st[i] <= SFC_EDGE_PULSE;
              pulse_cnt[i] <= pulse_cycles;
            end
          end
          SFC_EDGE_PULSE: begin
            pulse_cnt[i] <= PW_W'(pulse_cnt[i] - 1'b1);
            if (pulse_cnt[i] == PW_W'(1)) edge_st[i] <= SFC_EDGE_IDLE;
          end
          default: edge_st[i] <= SFC_EDGE_IDLE;
        endcase
      end
    end
  end

  // Outputs registered.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      supply_fault_detector_out <= '0;
      warning_out <= '0;
      warning_any_out <= 1'b0;
      logic_input_out <= '0;
      pull_down_en_out <= '0;
    end else begin
      for (int i = 0; i < NUM_DED; i++) begin
        supply_fault_detector_out[i] <= filt_out[i];
        supply_fault_detector_out[i+NUM_DED] <= !logic_mode[i] &&
          filt_out[i+NUM_DED];
        warning_out[i] <= logic_mode[i] && filt_out[i+NUM_DED];
        if (!logic_mode[i]) logic_input_out[i] <= 1'b0;
        else if (edge_mode[i])
          logic_input_out[i] <= edge_st[i] == SFC_EDGE_PULSE;
        else logic_input_out[i] <= dfilt_out[i];
      end
      warning_any_out <= |(logic_mode & filt_out[NUM_CH-1:NUM_DED]);
      pull_down_en_out <= logic_mode & pd_sel;
    end
  end

  // On-chip 100 kHz timing clock divided from the core clock.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      osc_cnt <= '0;
      osc_clk_out <= 1'b0;
    end else if (osc_cnt == 16'(OSC_HALF - 1)) begin
      osc_cnt <= '0;
      osc_clk_out <= !osc_clk_out;
    end else begin
      osc_cnt <= 16'(osc_cnt + 1'b1);
    end
  end
endmodule : sfc_top

// ==== tb/sfc_top_assertions.sv ====
`timescale 1ns/1ps
module sfc_top_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [sfc_pkg::NUM_CH-1:0][sfc_pkg::MV_W-1:0] input_mv_in,
  input wire logic [sfc_pkg::NUM_DUAL-1:0] dual_function_input_in,
  input wire logic [sfc_pkg::APB_AW-1:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [sfc_pkg::NUM_CH-1:0] supply_fault_detector_out,
  input wire logic [sfc_pkg::NUM_DED-1:0] warning_out,
  input wire logic warning_any_out,
  input wire logic [sfc_pkg::NUM_DUAL-1:0] logic_input_out,
  input wire logic [sfc_pkg::NUM_DUAL-1:0] pull_down_en_out,
  input wire logic osc_clk_out
);
  import sfc_pkg::*;
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // The half period is counted here because a 500-long repetition would
  // be far too costly to unroll.
  logic [9:0] osc_cnt;
  logic osc_seen;
  logic osc_q;
  always_ff @(posedge core_clk_in) begin
    osc_q <= osc_clk_out;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      osc_cnt <= 10'h000;
      osc_seen <= 1'b0;
    end else if (osc_clk_out != osc_q) begin
      osc_cnt <= 10'h001;
      osc_seen <= 1'b1;
    end else begin
      osc_cnt <= osc_cnt + 10'h001;
    end
  end
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_quiet;
    $stable(supply_fault_detector_out) && $stable(warning_out);
  endsequence
  sequence s_stat_rd;
    s_setup ##0 (!pwrite_in && paddr_in == ADDR_STATUS) ##0 s_quiet
      ##1 s_quiet;
  endsequence
  property p_apb_answer;
    s_setup |=> pready_out;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("no ready in the cycle after setup");
  property p_apb_pulse;
    pready_out |=> !pready_out;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse)
    else $error("ready held longer than one cycle");
  property p_err_ready;
    pslverr_out |-> pready_out;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("slave error without ready");
  property p_status_read;
    s_stat_rd |-> prdata_out[9:0] == supply_fault_detector_out
      && prdata_out[20:16] == warning_out;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read differs from live outputs");
  property p_warn_any_hi;
    (|warning_out) && $stable(warning_out) |-> warning_any_out;
  endproperty
  a_warn_any_hi: assert property (p_warn_any_hi)
    else $error("summary warning low while a warning is set");
  property p_warn_any_lo;
    warning_out == 5'h00 && $stable(warning_out) |-> !warning_any_out;
  endproperty
  a_warn_any_lo: assert property (p_warn_any_lo)
    else $error("summary warning high with no warning set");
  property p_osc_period;
    osc_seen && $changed(osc_clk_out) |-> osc_cnt == 10'h1f4;
  endproperty
  a_osc_period: assert property (p_osc_period)
    else $error("oscillator half period is not 500 cycles");
  property p_osc_bound;
    osc_seen |-> osc_cnt <= 10'h1f4;
  endproperty
  a_osc_bound: assert property (p_osc_bound)
    else $error("oscillator stopped toggling");
  property p_dual_excl;
    |(pull_down_en_out & $past(pull_down_en_out)) |->
      (supply_fault_detector_out[NUM_CH-1:NUM_DED] & pull_down_en_out)
      == 5'h00;
  endproperty
  a_dual_excl: assert property (p_dual_excl)
    else $error("logic-mode input still reports an analog fault");
endmodule : sfc_top_checker

bind sfc_top sfc_top_checker u_sfc_top_checker (.*);

// ==== tb/sfc_rail_model.sv ====
`timescale 1ns/1ps
module sfc_rail_model (
  input wire logic core_clk_in,
  input wire logic [sfc_pkg::NUM_DUAL-1:0] pull_down_en_in,
  output logic [sfc_pkg::NUM_CH-1:0][sfc_pkg::MV_W-1:0] input_mv_out,
  output logic [sfc_pkg::NUM_DUAL-1:0] pin_out
);
  import sfc_pkg::*;
  logic [NUM_DUAL-1:0] drv_val = '0;
  logic [NUM_DUAL-1:0] released = '0;
  logic [NUM_DUAL-1:0] stray = '0;
  initial input_mv_out = '0;
  // A released pin without its pull-down shows the inverse of its last
  // driven level, so a missing pull-down reads high instead of low.
  always @(posedge core_clk_in) stray <= ~drv_val;
  assign pin_out = (drv_val & ~released)
    | (stray & released & ~pull_down_en_in);
  task automatic set_mv(input int ch, input int mv);
    input_mv_out[ch] <= MV_W'(mv);
  endtask : set_mv
  task automatic set_pin(input int i, input logic v, input logic fl);
    drv_val[i] <= v;
    released[i] <= fl;
  endtask : set_pin
endmodule : sfc_rail_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import sfc_pkg::*;
  localparam int FN = 8;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [APB_AW-1:0] paddr_in = '0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [31:0] pwdata_in = '0;
  logic [3:0] pstrb_in = 4'hf;
  logic [NUM_CH-1:0][MV_W-1:0] input_mv_in;
  logic [NUM_DUAL-1:0] dual_function_input_in;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, warning_any_out, osc_clk_out;
  logic [NUM_CH-1:0] supply_fault_detector_out;
  logic [NUM_DED-1:0] warning_out;
  logic [NUM_DUAL-1:0] logic_input_out, pull_down_en_out;
  int n_errors = 0;
  int total_checks = 0;
  int span[4] = '{SPAN_MV_0, SPAN_MV_1, SPAN_MV_2, SPAN_MV_3};
  int bot[4] = '{BOT_MV_0, BOT_MV_1, BOT_MV_2, BOT_MV_3};
  int tch[6] = '{0, 1, 2, 4, 5, 3};
  int trg[6] = '{0, 1, 2, 3, 0, 2};
  int tmd[6] = '{0, 1, 3, 3, 1, 0};
  int u, o, hm, md, pf;
  logic [31:0] rd;
  logic er;
  always #5 core_clk_in = ~core_clk_in;
  sfc_top u_sfc_top (.*);
  sfc_rail_model u_sfc_rail_model (
    .core_clk_in(core_clk_in),
    .pull_down_en_in(pull_down_en_out),
    .input_mv_out(input_mv_in),
    .pin_out(dual_function_input_in)
  );
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk_in);
    paddr_in <= a;
    pwrite_in <= w;
    pwdata_in <= d;
    psel_in <= 1'b1;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    for (k = 0; k < 20 && pready_out !== 1'b1; k++) begin
      @(posedge core_clk_in);
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (k == 20) begin
      n_errors++;
      wrap_up();
    end
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc
  function automatic int mdl(int p, int v);
    int uf;
    int of;
    uf = (md != MODE_OV) && (v < u || (p != 0 && v < u + hm));
    of = (md != MODE_UV) && (v > o || (p != 0 && v + hm > o));
    return uf || of;
  endfunction : mdl
  task automatic step(input int ch, input int v);
    int e;
    e = mdl(pf, v);
    @(posedge core_clk_in);
    u_sfc_rail_model.set_mv(ch, v);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("fault_before", pf, supply_fault_detector_out[ch]);
    @(posedge core_clk_in);
    #1;
    chk("fault_after", e, supply_fault_detector_out[ch]);
    pf = e;
  endtask : step
  task automatic det(input int ch, input int r, input int m);
    int nu, no, h;
    int vs[10];
    logic [31:0] w;
    nu = 20 + $urandom_range(60);
    no = 160 + $urandom_range(60);
    h = 1 + $urandom_range(30);
    u = span[r] * nu / CODE_FULL + bot[r];
    o = span[r] * no / CODE_FULL + bot[r];
    hm = span[r] * h / CODE_FULL;
    md = m;
    pf = 0;
    w = 32'(nu + (no << 8) + (h << 16) + (r << 21) + (m << 24)) | 32'h0400_0000;
    vs = '{u - 1, u, u + hm - 1, u + hm, (u + o) / 2,
           o + 1, o, o - hm + 1, o - hm, (u + o) / 2};
    @(posedge core_clk_in);
    u_sfc_rail_model.set_mv(ch, (u + o) / 2);
    apb(ADDR_CH_BASE + 8'(ch * 4), 1'b1, w);
    rdc("ch_cfg", ADDR_CH_BASE + 8'(ch * 4), w);
    foreach (vs[i]) step(ch, vs[i]);
  endtask : det
  function automatic logic probe(int s);
    return s < 5 ? logic_input_out[s] : warning_out[s - 5];
  endfunction : probe
  task automatic wait_on(input int s, input logic v);
    int k;
    for (k = 0; k < 60 && probe(s) !== v; k++) begin
      @(posedge core_clk_in);
      #1;
    end
    chk("settled", v, probe(s));
    if (k == 60) wrap_up();
  endtask : wait_on
  task automatic edge_pw(input logic v, input int pw);
    int n;
    n = 0;
    @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(1, v, 1'b0);
    repeat (60) begin
      @(posedge core_clk_in);
      #1;
      n += (logic_input_out[1] === 1'b1);
    end
    chk("edge_pulse_width", pw, n);
  endtask : edge_pw
  initial begin
    #900_000;
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h5ddc570a));
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc("ch0_reset", ADDR_CH_BASE, 32'h0000_ff00);
    rdc("ch4_reset", ADDR_CH_BASE + 8'h10, 32'h0040_ff00);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    chk("unmapped_err", 1'b1, er);
    foreach (tch[i]) det(tch[i], trg[i], tmd[i]);
    apb(ADDR_CH_BASE + 8'h10, 1'b1, 32'h0200_ff00);
    rdc("ch4_range", ADDR_CH_BASE + 8'h10, 32'h0340_ff00);
    apb(ADDR_CH_BASE + 8'h24, 1'b1, 32'h0060_ff00);
    rdc("dual_range", ADDR_CH_BASE + 8'h24, 32'h0000_ff00);
    u = span[0] * 100 / CODE_FULL + bot[0];
    u_sfc_rail_model.set_mv(0, u + 50);
    apb(ADDR_FILT, 1'b1, 32'h0000_ffff);
    rdc("filt_clamp", ADDR_FILT, 32'h0000_2710);
    apb(ADDR_FILT, 1'b1, 32'(FN));
    apb(ADDR_CH_BASE, 1'b1, 32'h0400_0064);
    repeat (12) @(posedge core_clk_in);
    u_sfc_rail_model.set_mv(0, u - 1);
    repeat (FN - 1) @(posedge core_clk_in);
    u_sfc_rail_model.set_mv(0, u + 50);
    repeat (20) begin
      @(posedge core_clk_in);
      #1;
      chk("glitch", 1'b0, supply_fault_detector_out[0]);
    end
    @(posedge core_clk_in);
    u_sfc_rail_model.set_mv(0, u - 1);
    repeat (FN + 2) @(posedge core_clk_in);
    #1;
    chk("filt_early", 1'b0, supply_fault_detector_out[0]);
    @(posedge core_clk_in);
    #1;
    chk("filt_lag", 1'b1, supply_fault_detector_out[0]);
    @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(2, 1'b0, 1'b1);
    apb(ADDR_PULSE, 1'b1, 32'h0000_0006);
    apb(ADDR_CTRL, 1'b1, 32'h0004_021f);
    rdc("ctrl", ADDR_CTRL, 32'h0004_021f);
    #1;
    chk("pull_down_en", 5'h04, pull_down_en_out);
    chk("dual_faults", 5'h00, supply_fault_detector_out[9:5]);
    @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(0, 1'b1, 1'b0);
    repeat (FN - 1) @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(0, 1'b0, 1'b0);
    repeat (20) begin
      @(posedge core_clk_in);
      #1;
      chk("bounce", 1'b0, logic_input_out[0]);
    end
    chk("floating_low", 1'b0, logic_input_out[2]);
    @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(0, 1'b1, 1'b0);
    wait_on(0, 1'b1);
    @(posedge core_clk_in);
    u_sfc_rail_model.set_pin(0, 1'b0, 1'b0);
    wait_on(0, 1'b0);
    edge_pw(1'b1, 6);
    edge_pw(1'b0, 6);
    apb(ADDR_PULSE, 1'b1, 32'h0000_0000);
    edge_pw(1'b1, 0);
    // Rail 0 range differs from the dual's own, so the warning threshold
    // shows which range the warning detector really uses.
    apb(ADDR_CH_BASE, 1'b1, 32'h0420_0000);
    apb(ADDR_CH_BASE + 8'h14, 1'b1, 32'h0400_0096);
    u = span[1] * 150 / CODE_FULL + bot[1];
    u_sfc_rail_model.set_mv(0, u - 79);
    wait_on(5, 1'b1);
    apb(ADDR_STATUS, 1'b1, 32'hffff_ffff);
    rdc("status", ADDR_STATUS, 32'h0101_0000);
    chk("warning_any", 1'b1, warning_any_out);
    u_sfc_rail_model.set_mv(0, u);
    wait_on(5, 1'b0);
    rdc("status_clear", ADDR_STATUS, 32'h0000_0000);
    wrap_up();
  end
endmodule : testbench
